/* cem_pkg.sv */
// Package holding the constants of the configurable embedded multiplier.
package cem_pkg;
  localparam int unsigned CEM_WIDE_W = 18;
  localparam int unsigned CEM_NARROW_W = 9;
  localparam int unsigned CEM_PROD_W = 36;
  localparam int unsigned CEM_HALF_PROD_W = 18;
  localparam int unsigned CEM_LINK_IN_W = 16;
  localparam int unsigned CEM_LINK_OUT_W = 18;
  localparam int unsigned CEM_ADDR_W = 8;
  localparam logic [7:0] CEM_OFS_CFG = 8'h00;
  localparam logic [7:0] CEM_OFS_CTL = 8'h04;
  localparam logic [7:0] CEM_OFS_SIGN = 8'h08;
  localparam logic [7:0] CEM_OFS_OPA = 8'h0c;
  localparam logic [7:0] CEM_OFS_OPB = 8'h10;
  localparam logic [7:0] CEM_OFS_RES_LO = 8'h14;
  localparam logic [7:0] CEM_OFS_RES_HI = 8'h18;
  localparam logic [7:0] CEM_OFS_STATUS = 8'h1c;
  localparam int unsigned CEM_CFG_NARROW = 0;
  localparam int unsigned CEM_CFG_IN_REG = 1;
  localparam int unsigned CEM_CFG_OUT_REG = 2;
  localparam int unsigned CEM_CFG_LINK_SRC = 3;
  localparam int unsigned CEM_CTL_RUN = 0;
  localparam int unsigned CEM_CTL_CLKENA = 1;
  localparam int unsigned CEM_CTL_ACLR = 2;
  localparam int unsigned CEM_SIGN_A = 0;
  localparam int unsigned CEM_SIGN_B = 1;
  localparam int unsigned CEM_ST_SIGNED = 0;
  localparam int unsigned CEM_ST_LOCKED = 1;
  localparam int unsigned CEM_ST_VALID = 2;
  localparam logic [3:0] CEM_CFG_RESET = 4'h0;
  localparam logic [2:0] CEM_CTL_RESET = 3'h2;
  localparam logic [1:0] CEM_SIGN_RESET = 2'h0;
  typedef enum logic [1:0] {
    CEM_APB_IDLE = 2'b00,
    CEM_APB_ANSWER = 2'b01
  } cem_apb_e;
endpackage

/* cem_mult_if.sv */
// Interface carrying operands, sign controls and product between top and core.
`timescale 1ns/1ps
`default_nettype none
interface cem_mult_if;
  import cem_pkg::*;
  logic narrow;
  logic sign_a;
  logic sign_b;
  logic [CEM_WIDE_W-1:0] op_a;
  logic [CEM_WIDE_W-1:0] op_b;
  logic [CEM_PROD_W-1:0] product;
  logic product_signed;
  modport top (output narrow, output sign_a, output sign_b, output op_a, output op_b,
    input product, input product_signed);
  modport core (input narrow, input sign_a, input sign_b, input op_a, input op_b,
    output product, output product_signed);
endinterface
`default_nettype wire

/* cem_stage.sv */
// Optional register stage with shared enable and clear, or a plain bypass.
`timescale 1ns/1ps
`default_nettype none
module cem_stage #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic use_reg_i,
  input wire logic ena_i,
  input wire logic clr_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] q_reg;
  // Clear wins over the enable; enable low holds the stored value.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || clr_i) begin
      q_reg <= '0;
    end else if (ena_i) begin
      q_reg <= d_i;
    end
  end
  // The clear also masks the stored value at once, so it acts without waiting for an edge.
  always_comb begin
    if (!use_reg_i) begin
      q_o = d_i;
    end else if (clr_i) begin
      q_o = '0;
    end else begin
      q_o = q_reg;
    end
  end
endmodule // cem_stage
`default_nettype wire

/* cem_core.sv */
// Multiplier array: one wide product or two independent narrow products.
`timescale 1ns/1ps
`default_nettype none
module cem_core
  import cem_pkg::*;
(
  cem_mult_if.core mif
);
  // Extends an 18-bit operand by one bit, signed or zero as its flag says.
  function automatic logic signed [CEM_WIDE_W:0] cem_ext18(input logic [CEM_WIDE_W-1:0] v,
                                                          input logic sgn);
    cem_ext18 = {sgn & v[CEM_WIDE_W-1], v};
  endfunction
  // Widens a 9-bit operand to 18 bits, signed or zero as its flag says.
  function automatic logic [CEM_WIDE_W-1:0] cem_ext9(input logic [CEM_NARROW_W-1:0] v,
                                                    input logic sgn);
    cem_ext9 = {{CEM_NARROW_W{sgn & v[CEM_NARROW_W-1]}}, v};
  endfunction
  // Full precision product; the 38-bit signed result holds every case exactly.
  function automatic logic [CEM_PROD_W-1:0] cem_mul(input logic [CEM_WIDE_W-1:0] a,
                                                   input logic sa,
                                                   input logic [CEM_WIDE_W-1:0] b,
                                                   input logic sb);
    logic signed [2*CEM_WIDE_W+1:0] p;
    p = cem_ext18(a, sa) * cem_ext18(b, sb);
    cem_mul = p[CEM_PROD_W-1:0];
  endfunction
  logic [CEM_PROD_W-1:0] wide_p;
  logic [CEM_PROD_W-1:0] lo_p;
  logic [CEM_PROD_W-1:0] hi_p;
  always_comb begin
    wide_p = cem_mul(mif.op_a, mif.sign_a, mif.op_b, mif.sign_b);
    // Both narrow halves share the single pair of sign flags.
    lo_p = cem_mul(cem_ext9(mif.op_a[CEM_NARROW_W-1:0], mif.sign_a), mif.sign_a,
                   cem_ext9(mif.op_b[CEM_NARROW_W-1:0], mif.sign_b), mif.sign_b);
    hi_p = cem_mul(cem_ext9(mif.op_a[CEM_WIDE_W-1:CEM_NARROW_W], mif.sign_a), mif.sign_a,
                   cem_ext9(mif.op_b[CEM_WIDE_W-1:CEM_NARROW_W], mif.sign_b), mif.sign_b);
    if (mif.narrow) begin
      mif.product = {hi_p[CEM_HALF_PROD_W-1:0], lo_p[CEM_HALF_PROD_W-1:0]};
    end else begin
      mif.product = wide_p;
    end
    mif.product_signed = mif.sign_a | mif.sign_b;
  end
endmodule // cem_core
`default_nettype wire

/* cem_top.sv */
// Configurable embedded multiplier with APB registers and direct-link ports.
`timescale 1ns/1ps
`default_nettype none
module cem_top
  import cem_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [CEM_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [CEM_LINK_IN_W-1:0] link_left_i,
  input wire logic [CEM_LINK_IN_W-1:0] link_right_i,
  output logic [CEM_LINK_OUT_W-1:0] link_left_o,
  output logic [CEM_LINK_OUT_W-1:0] link_right_o,
  output logic product_signed_o
);
  cem_mult_if mif ();

  logic [3:0] cfg_reg;
  logic [2:0] ctl_reg;
  logic [1:0] sign_reg;
  logic [CEM_WIDE_W-1:0] opa_reg;
  logic [CEM_WIDE_W-1:0] opb_reg;
  logic [CEM_PROD_W-1:0] result_reg;
  logic result_signed_reg;
  logic valid_reg;
  logic [1:0] pipe_reg;
  logic [1:0] pipe_next;
  cem_apb_e apb_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [CEM_LINK_OUT_W-1:0] link_left_reg;
  logic [CEM_LINK_OUT_W-1:0] link_right_reg;

  logic wr_fire;
  logic rd_fire;
  logic addr_ok;
  logic run;
  logic ena;
  logic clr;
  logic op_write;
  logic [CEM_WIDE_W-1:0] src_a;
  logic [CEM_WIDE_W-1:0] src_b;
  logic [CEM_WIDE_W-1:0] stg_a;
  logic [CEM_WIDE_W-1:0] stg_b;
  logic [1:0] stg_sign;
  logic [CEM_PROD_W:0] stg_prod;
  logic [1:0] stage_depth;

  // Decodes whether an offset names one of the eight registers.
  function automatic logic cem_mapped(input logic [CEM_ADDR_W-1:0] a);
    case (a)
      CEM_OFS_CFG, CEM_OFS_CTL, CEM_OFS_SIGN, CEM_OFS_OPA, CEM_OFS_OPB,
      CEM_OFS_RES_LO, CEM_OFS_RES_HI, CEM_OFS_STATUS: cem_mapped = 1'b1;
      default: cem_mapped = 1'b0;
    endcase
  endfunction

  assign addr_ok = cem_mapped(paddr_i);
  // A transfer completes on the edge where the registered ready is seen high.
  assign wr_fire = psel_i && penable_i && pready_reg && pwrite_i && addr_ok;
  assign rd_fire = psel_i && penable_i && pready_reg && !pwrite_i;
  assign run = ctl_reg[CEM_CTL_RUN];
  // One enable and one clear drive every stage of the block.
  assign ena = ctl_reg[CEM_CTL_CLKENA];
  assign clr = ctl_reg[CEM_CTL_ACLR];
  assign op_write = wr_fire && ((paddr_i == CEM_OFS_OPA) || (paddr_i == CEM_OFS_OPB));

  // APB answer: one wait state, so ready, data and error all come from flops.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      apb_reg <= CEM_APB_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      case (apb_reg)
        CEM_APB_IDLE: begin
          if (psel_i && penable_i) begin
            apb_reg <= CEM_APB_ANSWER;
            pready_reg <= 1'b1;
            pslverr_reg <= !addr_ok;
          end
        end
        CEM_APB_ANSWER: begin
          apb_reg <= CEM_APB_IDLE;
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
        end
        default: begin
          apb_reg <= CEM_APB_IDLE;
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_reg == CEM_APB_IDLE && psel_i && penable_i && !pwrite_i) begin
      case (paddr_i)
        CEM_OFS_CFG: prdata_reg <= {28'h0, cfg_reg};
        CEM_OFS_CTL: prdata_reg <= {29'h0, ctl_reg};
        CEM_OFS_SIGN: prdata_reg <= {30'h0, sign_reg};
        CEM_OFS_OPA: prdata_reg <= {14'h0, opa_reg};
        CEM_OFS_OPB: prdata_reg <= {14'h0, opb_reg};
        CEM_OFS_RES_LO: prdata_reg <= result_reg[31:0];
        CEM_OFS_RES_HI: prdata_reg <= {28'h0, result_reg[CEM_PROD_W-1:32]};
        CEM_OFS_STATUS: prdata_reg <= {29'h0, valid_reg, run, result_signed_reg};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end else if (rd_fire) begin
      prdata_reg <= 32'h0000_0000;
    end
  end

  // Mode and stage use are frozen while running, so a write then is dropped.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cfg_reg <= CEM_CFG_RESET;
    end else if (wr_fire && paddr_i == CEM_OFS_CFG && !run) begin
      cfg_reg <= pwdata_i[3:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctl_reg <= CEM_CTL_RESET;
    end else if (wr_fire && paddr_i == CEM_OFS_CTL) begin
      ctl_reg <= pwdata_i[2:0];
    end
  end

  // Sign flags may be rewritten at any time and feed the input stage with the data.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sign_reg <= CEM_SIGN_RESET;
    end else if (wr_fire && paddr_i == CEM_OFS_SIGN) begin
      sign_reg <= pwdata_i[1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      opa_reg <= '0;
    end else if (wr_fire && paddr_i == CEM_OFS_OPA) begin
      opa_reg <= pwdata_i[CEM_WIDE_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      opb_reg <= '0;
    end else if (wr_fire && paddr_i == CEM_OFS_OPB) begin
      opb_reg <= pwdata_i[CEM_WIDE_W-1:0];
    end
  end

  // Link inputs fill the low sixteen bits; the top bits come from the operand registers.
  always_comb begin
    if (cfg_reg[CEM_CFG_LINK_SRC]) begin
      src_a = {opa_reg[CEM_WIDE_W-1:CEM_LINK_IN_W], link_left_i};
      src_b = {opb_reg[CEM_WIDE_W-1:CEM_LINK_IN_W], link_right_i};
    end else begin
      src_a = opa_reg;
      src_b = opb_reg;
    end
  end

  cem_stage #(.WIDTH(2*CEM_WIDE_W+2)) u_in_stage (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .use_reg_i(cfg_reg[CEM_CFG_IN_REG]),
    .ena_i(ena),
    .clr_i(clr),
    .d_i({sign_reg, src_a, src_b}),
    .q_o({stg_sign, stg_a, stg_b})
  );

  assign mif.narrow = cfg_reg[CEM_CFG_NARROW];
  assign mif.sign_a = stg_sign[CEM_SIGN_A];
  assign mif.sign_b = stg_sign[CEM_SIGN_B];
  assign mif.op_a = stg_a;
  assign mif.op_b = stg_b;

  cem_core u_core (
    .mif(mif)
  );

  cem_stage #(.WIDTH(CEM_PROD_W+1)) u_out_stage (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .use_reg_i(cfg_reg[CEM_CFG_OUT_REG]),
    .ena_i(ena),
    .clr_i(clr),
    .d_i({mif.product_signed, mif.product}),
    .q_o(stg_prod)
  );

  // The final capture also honours enable and clear, as the input and output stages do.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || clr) begin
      result_reg <= '0;
      result_signed_reg <= 1'b0;
      link_left_reg <= '0;
      link_right_reg <= '0;
    end else if (ena && run) begin
      result_reg <= stg_prod[CEM_PROD_W-1:0];
      result_signed_reg <= stg_prod[CEM_PROD_W];
      link_left_reg <= stg_prod[CEM_LINK_OUT_W-1:0];
      link_right_reg <= stg_prod[CEM_PROD_W-1:CEM_LINK_OUT_W];
    end
  end

  // Number of register stages an operand must cross before the result capture sees it.
  assign stage_depth = {1'b0, cfg_reg[CEM_CFG_IN_REG]} + {1'b0, cfg_reg[CEM_CFG_OUT_REG]};

  // Counts enabled edges since the last operand write; it saturates, so run may come late.
  always_comb begin
    pipe_next = pipe_reg;
    if (op_write) begin
      pipe_next = 2'h0;
    end else if (ena && pipe_reg != 2'h3) begin
      pipe_next = pipe_reg + 2'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || clr) begin
      pipe_reg <= 2'b00;
      valid_reg <= 1'b0;
    end else begin
      pipe_reg <= pipe_next;
      if (op_write) begin
        valid_reg <= 1'b0;
      end else if (ena && run && pipe_reg >= stage_depth) begin
        valid_reg <= 1'b1;
      end
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign link_left_o = link_left_reg;
  assign link_right_o = link_right_reg;
  assign product_signed_o = result_signed_reg;
endmodule // cem_top
`default_nettype wire

/* cem_top_checker.sv */
// Port-level assertion checker for the configurable embedded multiplier.
`timescale 1ns/1ps
`default_nettype none
module cem_top_checker
  import cem_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [CEM_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [CEM_LINK_IN_W-1:0] link_left_i,
  input wire logic [CEM_LINK_IN_W-1:0] link_right_i,
  input wire logic [CEM_LINK_OUT_W-1:0] link_left_o,
  input wire logic [CEM_LINK_OUT_W-1:0] link_right_o,
  input wire logic product_signed_o
);
  logic [3:0] cfg_reg;
  logic [2:0] ctl_reg;
  logic [1:0] sgn_reg;
  logic [2:0] hist_reg;
  logic wr;
  logic ok;
  assign wr = psel_i & penable_i & pready_o & pwrite_i;
  assign ok = ctl_reg[0] & ctl_reg[1] & ~ctl_reg[2];
  // Shadow copies follow the same write edges as the block, so no internal probing is needed.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cfg_reg <= CEM_CFG_RESET;
      ctl_reg <= CEM_CTL_RESET;
      sgn_reg <= CEM_SIGN_RESET;
      hist_reg <= 3'h0;
    end else begin
      hist_reg <= {hist_reg[1:0], |sgn_reg};
      if (wr && paddr_i == CEM_OFS_CFG && !ctl_reg[0]) begin
        cfg_reg <= pwdata_i[3:0];
      end
      if (wr && paddr_i == CEM_OFS_CTL) begin
        ctl_reg <= pwdata_i[2:0];
      end
      if (wr && paddr_i == CEM_OFS_SIGN) begin
        sgn_reg <= pwdata_i[1:0];
      end
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  AST_READY_SLOT: assert property (psel_i && !penable_i ##1 psel_i && penable_i
    |-> !pready_o ##1 pready_o) else $error("ready not in second access cycle");
  AST_READY_PULSE: assert property (pready_o |=> !pready_o) else $error("ready too long");
  AST_SETUP_QUIET: assert property (psel_i && !penable_i |-> !pready_o)
    else $error("ready in setup cycle");
  AST_ERR_MAP: assert property (pready_o |-> pslverr_o == (paddr_i > 8'h1c
    || paddr_i[1:0] != 2'h0)) else $error("error flag wrong for address");
  AST_RDATA_IDLE: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
    else $error("read bus not quiet");
  AST_HOLD: assert property (
    (!ctl_reg[0] || !ctl_reg[1]) && !ctl_reg[2]
    |=> $stable({link_right_o, link_left_o, product_signed_o})) else $error("result moved");
  AST_CLEAR: assert property (
    ctl_reg[2] && ctl_reg[0] && ctl_reg[1]
    |=> {link_right_o, link_left_o, product_signed_o} == 37'h0) else $error("clear missed");
  AST_SIGN_LAT: assert property (
    ok [*3] |=> product_signed_o == hist_reg[{1'b0, cfg_reg[1]} + {1'b0, cfg_reg[2]}])
    else $error("product sign wrong or misaligned");
  cover property (pready_o && pslverr_o);
  cover property (ok && cfg_reg[2:1] == 2'h3 && product_signed_o);
  cover property (ok && cfg_reg[0]);
endmodule // cem_top_checker
bind cem_top cem_top_checker u_chk (.ref_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .link_left_i, .link_right_i,
  .link_left_o, .link_right_o, .product_signed_o);
`default_nettype wire

/* cem_link_partner.sv */
// Model of the neighbouring logic that feeds the direct-link inputs.
`timescale 1ns/1ps
`default_nettype none
module cem_link_partner
  import cem_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic drive_i,
  input wire logic [CEM_LINK_IN_W-1:0] a_i,
  input wire logic [CEM_LINK_IN_W-1:0] b_i,
  output logic [CEM_LINK_IN_W-1:0] link_left_o,
  output logic [CEM_LINK_IN_W-1:0] link_right_o
);
  logic [CEM_LINK_IN_W-1:0] noise_reg;
  // Idle links churn every cycle, so any stray use of them corrupts the product.
  always_ff @(posedge ref_clk_i) begin
    noise_reg <= srst_i ? 16'h5a5a : ~noise_reg + 16'h1357;
  end
  assign link_left_o = drive_i ? a_i : noise_reg;
  assign link_right_o = drive_i ? b_i : ~noise_reg;
endmodule // cem_link_partner
`default_nettype wire

/* tb.sv */
// Self-checking bench for the configurable embedded multiplier.
`timescale 1ns/1ps
`default_nettype none
module tb
  import cem_pkg::*;
;
  typedef struct packed {
    logic [3:0] cfg;
    logic [1:0] sgn;
    logic [17:0] opa;
    logic [17:0] opb;
    logic [35:0] prod;
  } cem_row_s;
  localparam cem_row_s ROWS [8] = '{
    '{4'h0, 2'h0, 18'h3ffff, 18'h3ffff, 36'hffff80001},
    '{4'h2, 2'h3, 18'h3ffff, 18'h3ffff, 36'h000000001},
    '{4'h4, 2'h1, 18'h3ffff, 18'h3ffff, 36'hffffc0001},
    '{4'h6, 2'h2, 18'h20000, 18'h20000, 36'hc00000000},
    '{4'h1, 2'h3, 18'h3ff00, 18'h00300, 36'hffffd0000},
    '{4'h7, 2'h0, 18'h3ffff, 18'h005ff, 36'h00ffbfc01},
    '{4'h5, 2'h2, 18'h001ff, 18'h001ff, 36'h00003fe01},
    '{4'h8, 2'h0, 18'h30000, 18'h00000, 36'h0000f000f}};
  logic ref_clk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdata;
  logic [15:0] link_left_i, link_right_i;
  logic [17:0] link_left_o, link_right_o;
  logic product_signed_o, drive_link, rerr;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  cem_top uut (.ref_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .link_left_i, .link_right_i, .link_left_o,
    .link_right_o, .product_signed_o);
  cem_link_partner u_link (.ref_clk_i, .srst_i, .drive_i(drive_link), .a_i(16'h0003),
    .b_i(16'h0005), .link_left_o(link_left_i), .link_right_o(link_right_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    // Only the bench timeout ends a wait that never sees ready.
    do begin
      @(posedge ref_clk_i);
    end while (pready_o !== 1'b1);
    rdata = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input logic ee);
    apb(1'b0, a, 32'h0);
    chk({4'h0, rdata & m}, {4'h0, e});
    chk({35'h0, rerr}, {35'h0, ee});
  endtask
  // The wait covers the longest pipe: input stage, output stage, result register.
  task automatic out_chk(input logic [35:0] p, input logic s);
    repeat (4) @(posedge ref_clk_i);
    chk({link_right_o, link_left_o}, p);
    chk({35'h0, product_signed_o}, {35'h0, s});
  endtask
  task automatic load(input logic [3:0] c, input logic [1:0] s, input logic [17:0] a,
    input logic [17:0] b);
    wr(CEM_OFS_CTL, 32'h2);
    wr(CEM_OFS_CFG, {28'h0, c});
    wr(CEM_OFS_SIGN, {30'h0, s});
    wr(CEM_OFS_OPA, {14'h0, a});
    wr(CEM_OFS_OPB, {14'h0, b});
    wr(CEM_OFS_CTL, 32'h3);
  endtask
  initial begin
    srst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    drive_link = 1'b0;
    repeat (20) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      drive_link <= ROWS[i].cfg[3];
      load(ROWS[i].cfg, ROWS[i].sgn, ROWS[i].opa, ROWS[i].opb);
      out_chk(ROWS[i].prod, |ROWS[i].sgn);
      rd_chk(CEM_OFS_RES_LO, 32'hffffffff, ROWS[i].prod[31:0], 1'b0);
      rd_chk(CEM_OFS_RES_HI, 32'hf, {28'h0, ROWS[i].prod[35:32]}, 1'b0);
      rd_chk(CEM_OFS_STATUS, 32'h7, {29'h0, 2'h3, |ROWS[i].sgn}, 1'b0);
    end
    drive_link <= 1'b0;
    load(4'h2, 2'h0, 18'h3ffff, 18'h3ffff);
    out_chk(36'hffff80001, 1'b0);
    wr(CEM_OFS_SIGN, 32'h3);
    out_chk(36'h000000001, 1'b1);
    wr(CEM_OFS_CFG, 32'h1);
    rd_chk(CEM_OFS_CFG, 32'hf, 32'h2, 1'b0);
    wr(CEM_OFS_CTL, 32'h1);
    wr(CEM_OFS_OPA, 32'h2);
    out_chk(36'h000000001, 1'b1);
    wr(CEM_OFS_CTL, 32'h3);
    out_chk(36'hffffffffe, 1'b1);
    wr(CEM_OFS_CTL, 32'h7);
    out_chk(36'h0, 1'b0);
    rd_chk(8'h20, 32'hffffffff, 32'h0, 1'b1);
    rd_chk(8'h06, 32'hffffffff, 32'h0, 1'b1);
    srst_i <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rd_chk(CEM_OFS_CTL, 32'h7, 32'h2, 1'b0);
    rd_chk(CEM_OFS_CFG, 32'hf, 32'h0, 1'b0);
    rd_chk(CEM_OFS_STATUS, 32'h7, 32'h0, 1'b0);
    out_chk(36'h0, 1'b0);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
